//--- hw/msm_defines.svh
// register offsets, field positions and timing counts of the status monitor
`ifndef MSM_DEFINES_SVH
`define MSM_DEFINES_SVH
`define MSM_OFS_GAIN 6'h0A
`define MSM_OFS_FOFS0 6'h0B
`define MSM_OFS_FOFS1 6'h0C
`define MSM_OFS_FOFS2 6'h0D
`define MSM_OFS_LOCK 6'h0E
`define MSM_OFS_ISNR 6'h0F
`define MSM_OFS_DERR0 6'h10
`define MSM_OFS_DERR2 6'h12
`define MSM_OFS_FBIT0 6'h13
`define MSM_OFS_FBIT3 6'h16
`define MSM_OFS_PERR0 6'h17
`define MSM_OFS_PERR3 6'h1A
`define MSM_OFS_PSYNC 6'h1B
`define MSM_OFS_NET 6'h1C
`define MSM_OFS_PHYID 6'h1D
`define MSM_OFS_HWA0 6'h1E
`define MSM_OFS_HWA5 6'h23
`define MSM_OFS_IRQ_STAT 6'h24
`define MSM_OFS_IRQ_MASK 6'h25
`define MSM_OFS_ROUTE 6'h26
`define MSM_ROUTE_TP_BIT 7
`define MSM_LOCK_CARRIER_BIT 0
`define MSM_LOCK_DECODER_BIT 1
`define MSM_NET_MON_BIT 0
`define MSM_NET_DATA_BIT 1
`define MSM_PHASE_LIMIT_DEG 25
`define MSM_DEC_WINDOW_BITS 1000
`define MSM_PAT_WINDOW_BITS 1000000
`define MSM_PAT_PERIOD 2047
`define MSM_PAT_SYNC_RUN 32
`define MSM_PAT_LOSS_ERRS 64
`define MSM_DEMOD_LOCKED_STATE 2
`define MSM_NUM_EVENTS 6
`define MSM_NUM_TP 10
`endif

//--- hw/msm_pkg.sv
// types shared by the status monitor
package msm_pkg;
   typedef enum logic [1:0] {
      MSM_PAT_HUNT,
      MSM_PAT_LOCKED
   } msm_pat_state_e;
   typedef logic [7:0] msm_byte_t;
endpackage : msm_pkg

//--- hw/msm_status_monitor.sv
// status monitoring register bank of the psk modem receiver, read-only apart from route and mask
`timescale 1ns/1ps
`include "msm_defines.svh"

module msm_status_monitor
   import msm_pkg::*;
#(
   parameter int DEC_WINDOW = `MSM_DEC_WINDOW_BITS,
   parameter int PAT_WINDOW = `MSM_PAT_WINDOW_BITS,
   parameter logic [7:0] PHY_ID = 8'h5A, // arbitrary value
   parameter logic [47:0] HW_ADDR = 48'h02_00_00_00_00_01 // arbitrary value
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic irq_o,
   input wire logic [7:0] rx_gain_control_i,
   input wire logic [23:0] freq_offset_i,
   input wire logic carrier_lock_i,
   input wire logic [7:0] inverse_snr_i,
   input wire logic decoder_sync_flag_i,
   input wire logic dec_bit_valid_i,
   input wire logic dec_bit_error_i,
   input wire logic frame_bit_valid_i,
   input wire logic pat_bit_valid_i,
   input wire logic pat_bit_i,
   input wire logic mon_port_conn_i,
   input wire logic data_port_conn_i,
   input wire logic scan_carrier_i,
   input wire logic pll_carrier_i,
   input wire logic [1:0] demod_state_i,
   input wire logic ambiguity_step_i,
   input wire logic false_lock_reset_i,
   output logic [`MSM_NUM_TP-1:0] test_point_o,
   output logic [`MSM_NUM_TP-1:0] test_point_oe_n_o
);

   // ***********************************************************************
   // front-end sampling
   // ***********************************************************************

   // connection flags come from the network side, another clock: resync
   logic [1:0] net_meta_reg;
   logic [1:0] net_sync_reg;
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         net_meta_reg <= 2'h0;
         net_sync_reg <= 2'h0;
      end else begin
         net_meta_reg <= {data_port_conn_i, mon_port_conn_i};
         net_sync_reg <= net_meta_reg;
      end
   end

   // ***********************************************************************
   // decoder error window
   // ***********************************************************************

   logic [23:0] dec_acc_reg;
   logic [23:0] dec_result_reg;
   logic [31:0] dec_bits_reg;
   logic dec_wrap;
   assign dec_wrap = dec_bit_valid_i && (dec_bits_reg == 32'(DEC_WINDOW - 1));

   // error total latched at each window end, accumulator restarts
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dec_acc_reg <= 24'h0;
         dec_result_reg <= 24'h0;
         dec_bits_reg <= 32'h0;
      end else if (dec_bit_valid_i) begin
         if (dec_wrap) begin
            dec_bits_reg <= 32'h0;
            dec_result_reg <= dec_acc_reg + 24'(dec_bit_error_i);
            dec_acc_reg <= 24'h0;
         end else begin
            dec_bits_reg <= dec_bits_reg + 32'h1;
            dec_acc_reg <= dec_acc_reg + 24'(dec_bit_error_i);
         end
      end
   end

   // ***********************************************************************
   // cumulative framed bits
   // ***********************************************************************

   logic [31:0] frame_bits_reg;
   // free-running count, wraps silently after 2^32 bits
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_bits_reg <= 32'h0;
      end else if (frame_bit_valid_i) begin
         frame_bits_reg <= frame_bits_reg + 32'h1;
      end
   end

   // ***********************************************************************
   // prbs-11 tester
   // ***********************************************************************

   logic [10:0] prbs_reg;
   logic prbs_pred;
   logic pat_err;
   msm_pat_state_e pat_state_reg;
   logic [7:0] pat_run_reg;
   logic [7:0] pat_bad_reg;
   logic [31:0] pat_bits_reg;
   logic [31:0] pat_acc_reg;
   logic [31:0] pat_result_reg;
   logic [10:0] pat_pos_reg;
   logic pat_byte_err_reg;
   logic [2:0] pat_bitcnt_reg;

   // x^11 + x^9 + 1 predicted from the last eleven received bits
   assign prbs_pred = prbs_reg[10] ^ prbs_reg[8];
   assign pat_err = pat_bit_valid_i && (pat_bit_i != prbs_pred);

   // self-synchronising reference: shift in the received bit
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prbs_reg <= 11'h0;
      end else if (pat_bit_valid_i) begin
         prbs_reg <= {prbs_reg[9:0], pat_bit_i};
      end
   end

   // sync declared after a clean run, dropped after many errors
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pat_state_reg <= MSM_PAT_HUNT;
         pat_run_reg <= 8'h0;
         pat_bad_reg <= 8'h0;
      end else if (pat_bit_valid_i) begin
         case (pat_state_reg)
            MSM_PAT_HUNT: begin
               pat_bad_reg <= 8'h0;
               if (pat_err) begin
                  pat_run_reg <= 8'h0;
               end else if (pat_run_reg == 8'(`MSM_PAT_SYNC_RUN - 1)) begin
                  pat_state_reg <= MSM_PAT_LOCKED;
               end else begin
                  pat_run_reg <= pat_run_reg + 8'h1;
               end
            end
            MSM_PAT_LOCKED: begin
               pat_run_reg <= 8'h0;
               if (pat_bits_reg == 32'h0) begin
                  pat_bad_reg <= 8'h0;
               end else if (pat_err) begin
                  if (pat_bad_reg == 8'(`MSM_PAT_LOSS_ERRS - 1)) begin
                     pat_state_reg <= MSM_PAT_HUNT;
                  end else begin
                     pat_bad_reg <= pat_bad_reg + 8'h1;
                  end
               end
            end
            default: pat_state_reg <= MSM_PAT_HUNT;
         endcase
      end
   end

   logic pat_locked;
   assign pat_locked = (pat_state_reg == MSM_PAT_LOCKED);

   // window counter; the result is only replaced at the window end
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pat_bits_reg <= 32'h0;
         pat_acc_reg <= 32'h0;
         pat_result_reg <= 32'h0;
      end else if (pat_bit_valid_i) begin
         if (pat_bits_reg == 32'(PAT_WINDOW - 1)) begin
            pat_bits_reg <= 32'h0;
            pat_acc_reg <= 32'h0;
            pat_result_reg <= pat_acc_reg + 32'(pat_err);
         end else begin
            pat_bits_reg <= pat_bits_reg + 32'h1;
            pat_acc_reg <= pat_acc_reg + 32'(pat_err);
         end
      end
   end

   // byte error marker and periodic sequence start marker
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pat_pos_reg <= 11'h0;
         pat_bitcnt_reg <= 3'h0;
         pat_byte_err_reg <= 1'b0;
      end else if (pat_bit_valid_i) begin
         pat_pos_reg <= (pat_pos_reg == 11'(`MSM_PAT_PERIOD - 1)) ?
            11'h0 : pat_pos_reg + 11'h1;
         pat_bitcnt_reg <= pat_bitcnt_reg + 3'h1;
         pat_byte_err_reg <= (pat_bitcnt_reg == 3'h0) ? pat_err :
            (pat_byte_err_reg | pat_err);
      end
   end

   // ***********************************************************************
   // snapshot and register read
   // ***********************************************************************

   logic [23:0] snap_fofs_reg;
   logic [23:0] snap_derr_reg;
   logic [31:0] snap_fbit_reg;
   logic [31:0] snap_perr_reg;
   logic [`MSM_NUM_EVENTS-1:0] irq_stat_reg;
   logic [`MSM_NUM_EVENTS-1:0] irq_mask_reg;
   logic [7:0] route_reg;
   logic gain_rd;
   assign gain_rd = reg_rd_i && (reg_addr_i == `MSM_OFS_GAIN);

   // reading the gain byte freezes every multi-byte value at once
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         snap_fofs_reg <= 24'h0;
         snap_derr_reg <= 24'h0;
         snap_fbit_reg <= 32'h0;
         snap_perr_reg <= 32'h0;
      end else if (gain_rd) begin
         snap_fofs_reg <= freq_offset_i;
         snap_derr_reg <= dec_result_reg;
         snap_fbit_reg <= frame_bits_reg;
         snap_perr_reg <= pat_result_reg;
      end
   end

   // byte of a multi-byte field, lsb first
   function automatic msm_byte_t pick(input logic [31:0] v, input int idx);
      pick = v[idx*8 +: 8];
   endfunction : pick

   // combinational read mux; upper bits of flag bytes stay zero
   msm_byte_t rd_mux;
   always_comb begin
      rd_mux = 8'h0;
      if (reg_addr_i == `MSM_OFS_GAIN) begin
         rd_mux = rx_gain_control_i;
      end else if (reg_addr_i >= `MSM_OFS_FOFS0 &&
                   reg_addr_i <= `MSM_OFS_FOFS2) begin
         rd_mux = pick({8'h0, snap_fofs_reg},
                       int'(reg_addr_i - `MSM_OFS_FOFS0));
      end else if (reg_addr_i == `MSM_OFS_LOCK) begin
         rd_mux = {6'h0, decoder_sync_flag_i, carrier_lock_i};
      end else if (reg_addr_i == `MSM_OFS_ISNR) begin
         rd_mux = inverse_snr_i;
      end else if (reg_addr_i >= `MSM_OFS_DERR0 &&
                   reg_addr_i <= `MSM_OFS_DERR2) begin
         rd_mux = pick({8'h0, snap_derr_reg},
                       int'(reg_addr_i - `MSM_OFS_DERR0));
      end else if (reg_addr_i >= `MSM_OFS_FBIT0 &&
                   reg_addr_i <= `MSM_OFS_FBIT3) begin
         rd_mux = pick(snap_fbit_reg, int'(reg_addr_i - `MSM_OFS_FBIT0));
      end else if (reg_addr_i >= `MSM_OFS_PERR0 &&
                   reg_addr_i <= `MSM_OFS_PERR3) begin
         rd_mux = pick(snap_perr_reg, int'(reg_addr_i - `MSM_OFS_PERR0));
      end else if (reg_addr_i == `MSM_OFS_PSYNC) begin
         rd_mux = {7'h0, pat_locked};
      end else if (reg_addr_i == `MSM_OFS_NET) begin
         rd_mux = {6'h0, net_sync_reg};
      end else if (reg_addr_i == `MSM_OFS_PHYID) begin
         rd_mux = PHY_ID;
      end else if (reg_addr_i >= `MSM_OFS_HWA0 &&
                   reg_addr_i <= `MSM_OFS_HWA5) begin
         // first byte read is the most significant of the address
         rd_mux = HW_ADDR[(5 - int'(reg_addr_i - `MSM_OFS_HWA0))*8 +: 8];
      end else if (reg_addr_i == `MSM_OFS_IRQ_STAT) begin
         rd_mux = 8'(irq_stat_reg);
      end else if (reg_addr_i == `MSM_OFS_IRQ_MASK) begin
         rd_mux = 8'(irq_mask_reg);
      end else if (reg_addr_i == `MSM_OFS_ROUTE) begin
         rd_mux = route_reg;
      end
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 8'h0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 8'h0;
      end
   end

   // ***********************************************************************
   // control registers: only route and mask take writes
   // ***********************************************************************

   // status bytes have no write path at all
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         route_reg <= 8'h0;
         irq_mask_reg <= '0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `MSM_OFS_ROUTE) begin
            route_reg <= reg_wdata_i;
         end
         if (reg_addr_i == `MSM_OFS_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata_i[`MSM_NUM_EVENTS-1:0];
         end
      end
   end

   // ***********************************************************************
   // interrupts
   // ***********************************************************************

   logic carrier_lock_d_reg;
   logic dec_sync_d_reg;
   logic pat_locked_d_reg;
   logic [`MSM_NUM_EVENTS-1:0] irq_event;
   logic stat_rd;
   assign stat_rd = reg_rd_i && (reg_addr_i == `MSM_OFS_IRQ_STAT);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         carrier_lock_d_reg <= 1'b0;
         dec_sync_d_reg <= 1'b0;
         pat_locked_d_reg <= 1'b0;
      end else begin
         carrier_lock_d_reg <= carrier_lock_i;
         dec_sync_d_reg <= decoder_sync_flag_i;
         pat_locked_d_reg <= pat_locked;
      end
   end

   // events: lock changes, pattern sync change, window ends, false lock reset
   assign irq_event = {
      false_lock_reset_i,
      dec_wrap,
      pat_bit_valid_i && (pat_bits_reg == 32'(PAT_WINDOW - 1)),
      pat_locked ^ pat_locked_d_reg,
      decoder_sync_flag_i ^ dec_sync_d_reg,
      carrier_lock_i ^ carrier_lock_d_reg
   };

   // a read clears the status, but an event in that cycle survives
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (stat_rd ? '0 : irq_stat_reg) | irq_event;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((stat_rd ? '0 : irq_stat_reg) | irq_event) &
                    irq_mask_reg);
      end
   end

   // ***********************************************************************
   // test points
   // ***********************************************************************

   logic [`MSM_NUM_TP-1:0] tp_sig;
   assign tp_sig = {
      pat_bit_valid_i && (pat_pos_reg == 11'h0),
      pat_byte_err_reg,
      pat_locked,
      decoder_sync_flag_i,
      false_lock_reset_i,
      ambiguity_step_i,
      demod_state_i == 2'(`MSM_DEMOD_LOCKED_STATE),
      pll_carrier_i,
      scan_carrier_i,
      carrier_lock_i
   };

   // when disabled the pins float: enable high, data held low
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         test_point_o <= '0;
         test_point_oe_n_o <= '1;
      end else begin
         test_point_o <= route_reg[`MSM_ROUTE_TP_BIT] ? tp_sig : '0;
         test_point_oe_n_o <= {`MSM_NUM_TP{~route_reg[`MSM_ROUTE_TP_BIT]}};
      end
   end

   // ***********************************************************************
   // assertions
   // ***********************************************************************

   AST_RDATA_IDLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !reg_rd_i |=> reg_rdata_o == 8'h0)
      else $error("read data not zero after idle cycle");
   AST_GAIN_READ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      gain_rd |=> reg_rdata_o == $past(rx_gain_control_i))
      else $error("gain byte not returned");
   AST_LOCK_BYTE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == `MSM_OFS_LOCK |=> reg_rdata_o[7:2] == 6'h0 &&
      reg_rdata_o[0] == $past(carrier_lock_i))
      else $error("lock byte wrong");
   AST_DEC_SYNC: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == `MSM_OFS_LOCK
      |=> reg_rdata_o[1] == $past(decoder_sync_flag_i))
      else $error("decoder sync bit wrong");
   AST_ISNR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == `MSM_OFS_ISNR
      |=> reg_rdata_o == $past(inverse_snr_i))
      else $error("inverse snr wrong");
   AST_DEC_WINDOW: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !dec_wrap |=> $stable(dec_result_reg))
      else $error("decoder result moved inside window");
   AST_FRAME_COUNT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      frame_bit_valid_i |=> frame_bits_reg == $past(frame_bits_reg) + 32'h1)
      else $error("framed bit count did not step");
   AST_PAT_HOLD: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !(pat_bit_valid_i && pat_bits_reg == 32'(PAT_WINDOW - 1))
      |=> $stable(pat_result_reg))
      else $error("pattern result changed outside window end");
   AST_PAT_SYNC_BYTE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == `MSM_OFS_PSYNC
      |=> reg_rdata_o == {7'h0, $past(pat_locked)})
      else $error("pattern sync byte wrong");
   AST_SNAPSHOT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      gain_rd |=> snap_fbit_reg == $past(frame_bits_reg))
      else $error("snapshot not taken on gain read");
   AST_TP_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !route_reg[`MSM_ROUTE_TP_BIT] |=> test_point_oe_n_o == '1)
      else $error("test points driven while disabled");
   AST_NET_BYTE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_rd_i && reg_addr_i == `MSM_OFS_NET |=> reg_rdata_o[7:2] == 6'h0)
      else $error("connection byte upper bits set");

   COV_GAIN_SNAP: cover property (@(posedge core_clk_i) gain_rd);
   COV_PAT_LOCK: cover property (@(posedge core_clk_i) pat_locked && !pat_locked_d_reg);
   COV_IRQ: cover property (@(posedge core_clk_i) irq_o);
   COV_TP_ON: cover property (@(posedge core_clk_i) !test_point_oe_n_o[0]);

endmodule : msm_status_monitor

//--- tb/tb.sv
// self-checking bench of the status monitor register bank
`timescale 1ns/1ps
`include "msm_defines.svh"

module tb;
   // ************************************************************
   // stimulus signals and model state
   // ************************************************************
   localparam logic [7:0] PHY = 8'h3C; // arbitrary value
   localparam logic [47:0] HWA = 48'h0A_1B_2C_3D_4E_5F; // arbitrary value
   localparam int DEC_W = 10;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic irq_o;
   logic [7:0] gain_i = 8'h00;
   logic [23:0] fofs_i = 24'h000000;
   logic car_i = 1'b0;
   logic [7:0] isnr_i = 8'h00;
   logic dsync_i = 1'b0;
   logic dvld_i = 1'b0;
   logic derr_i = 1'b0;
   logic fvld_i = 1'b0;
   logic pvld_i = 1'b0;
   logic pbit_i = 1'b0;
   logic mon_i = 1'b0;
   logic data_i = 1'b0;
   logic scan_i = 1'b0;
   logic pll_i = 1'b0;
   logic [1:0] dstate_i = 2'h0;
   logic amb_i = 1'b0;
   logic flr_i = 1'b0;
   logic [9:0] tp_o;
   logic [9:0] tp_oe_n_o;
   integer bad_count = 0;
   integer check_count = 0;
   integer seed = 32'hB996;
   integer fbits_m = 0;
   integer derr_m = 0;
   integer i;
   logic [31:0] v;
   logic [31:0] r;
   logic [7:0] d;
   logic [10:0] s;

   msm_status_monitor #(.DEC_WINDOW(DEC_W), .PAT_WINDOW(20), .PHY_ID(PHY),
      .HW_ADDR(HWA)) dut (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .rx_gain_control_i(gain_i),
      .freq_offset_i(fofs_i), .carrier_lock_i(car_i), .inverse_snr_i(isnr_i),
      .decoder_sync_flag_i(dsync_i), .dec_bit_valid_i(dvld_i),
      .dec_bit_error_i(derr_i), .frame_bit_valid_i(fvld_i),
      .pat_bit_valid_i(pvld_i), .pat_bit_i(pbit_i), .mon_port_conn_i(mon_i),
      .data_port_conn_i(data_i), .scan_carrier_i(scan_i),
      .pll_carrier_i(pll_i), .demod_state_i(dstate_i),
      .ambiguity_step_i(amb_i), .false_lock_reset_i(flr_i),
      .test_point_o(tp_o), .test_point_oe_n_o(tp_oe_n_o));

   // 200 MHz clock
   always #2.5 core_clk_i = ~core_clk_i;

   // ************************************************************
   // bus and compare tasks
   // ************************************************************
   task automatic chk(input string n, input logic [47:0] e,
                      input logic [47:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one-cycle write; the slave never stalls
   task automatic wr(input logic [5:0] a, input logic [7:0] w);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= w;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      q = reg_rdata_o;
   endtask : rd

   // multi-byte value, least significant byte first
   task automatic rdn(input logic [5:0] a, input int n,
                      output logic [31:0] q);
      logic [7:0] b;
      q = 32'h0;
      for (int k = 0; k < n; k++) begin
         rd(a + 6'(k), b);
         q[8*k +: 8] = b;
      end
   endtask : rdn

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (2) @(posedge core_clk_i);
      chk("oe_n_rst", 48'h3FF, tp_oe_n_o);
      arst_n_i <= 1'b1;
      gain_i <= 8'($random(seed));
      fofs_i <= 24'($random(seed));
      isnr_i <= 8'($random(seed));
      rd(`MSM_OFS_PSYNC, d);
      chk("psync_hunt", 0, d);
      // snapshot taken by the gain read must survive input changes
      v = {8'h00, fofs_i};
      rd(`MSM_OFS_GAIN, d);
      chk("gain", gain_i, d);
      fofs_i <= ~fofs_i;
      rdn(`MSM_OFS_FOFS0, 3, r);
      chk("fofs", v, r);
      rd(`MSM_OFS_ISNR, d);
      chk("isnr", isnr_i, d);
      // every flag combination; writes must not disturb them
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk_i);
         car_i <= i[0];
         dsync_i <= i[1];
         mon_i <= i[0];
         data_i <= i[1];
         repeat (4) @(posedge core_clk_i);
         rd(`MSM_OFS_LOCK, d);
         chk("lock", i, d);
         rd(`MSM_OFS_NET, d);
         chk("net", i, d);
         wr(`MSM_OFS_LOCK, 8'hFF);
         rd(`MSM_OFS_LOCK, d);
         chk("lock_wr", i, d);
      end
      wr(6'h3F, 8'hA5);
      rd(6'h3F, d);
      chk("unmapped", 0, d);
      rd(`MSM_OFS_PHYID, d);
      chk("phy_id", PHY, d);
      for (i = 0; i < 6; i++) begin
         rd(`MSM_OFS_HWA0 + 6'(i), d);
         chk("hw_addr", HWA[47 - 8*i -: 8], d);
      end
      // random framed-bit pulses against an integer count
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk_i);
         v = $random(seed);
         fvld_i <= v[0];
         fbits_m += v[0];
      end
      @(posedge core_clk_i);
      fvld_i <= 1'b0;
      rd(`MSM_OFS_GAIN, d);
      rdn(`MSM_OFS_FBIT0, 4, r);
      chk("fbits", fbits_m, r);
      // one full decoder window with random channel errors
      for (i = 0; i < DEC_W; i++) begin
         @(posedge core_clk_i);
         v = $random(seed);
         dvld_i <= 1'b1;
         derr_i <= v[0];
         derr_m += v[0];
      end
      @(posedge core_clk_i);
      dvld_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rd(`MSM_OFS_GAIN, d);
      rdn(`MSM_OFS_DERR0, 3, r);
      chk("dec_errs", derr_m, r);
      // clean prbs-11 stream, b[n] = b[n-9] ^ b[n-11]
      s = 11'h001;
      for (i = 0; i < 100; i++) begin
         @(posedge core_clk_i);
         s = {s[9:0], s[8] ^ s[10]};
         pvld_i <= 1'b1;
         pbit_i <= s[0];
      end
      @(posedge core_clk_i);
      pvld_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rd(`MSM_OFS_PSYNC, d);
      chk("psync", 1, d);
      // host self check: write 03 to route, expect both locks up
      wr(`MSM_OFS_ROUTE, 8'h03);
      rd(`MSM_OFS_LOCK, d);
      chk("self_lock", 8'h03, d);
      for (i = 0; i < 2; i++) begin
         rd(`MSM_OFS_GAIN, d);
         rdn(`MSM_OFS_PERR0, 4, r);
         chk("pat_errs", 0, r);
      end
      // masked event still lands in status; unmasked raises the line
      wr(`MSM_OFS_IRQ_MASK, 8'h00);
      rd(`MSM_OFS_IRQ_STAT, d);
      @(posedge core_clk_i);
      car_i <= ~car_i;
      repeat (3) @(posedge core_clk_i);
      chk("irq_masked", 0, irq_o);
      rd(`MSM_OFS_IRQ_STAT, d);
      chk("stat_car", 1, d[0]);
      wr(`MSM_OFS_IRQ_MASK, 8'h20);
      rd(`MSM_OFS_IRQ_MASK, d);
      chk("mask", 8'h20, d);
      @(posedge core_clk_i);
      flr_i <= 1'b1;
      amb_i <= 1'b1;
      @(posedge core_clk_i);
      flr_i <= 1'b0;
      amb_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk("irq_on", 1, irq_o);
      rd(`MSM_OFS_IRQ_STAT, d);
      chk("stat_flr", 1, d[5]);
      chk("irq_clr", 0, irq_o);
      // test points float until enabled, then mirror the sources
      @(posedge core_clk_i);
      scan_i <= 1'b1;
      dstate_i <= 2'h2;
      wr(`MSM_OFS_ROUTE, 8'h00);
      repeat (3) @(posedge core_clk_i);
      chk("oe_off", 48'h3FF, tp_oe_n_o);
      wr(`MSM_OFS_ROUTE, 8'h80);
      repeat (3) @(posedge core_clk_i);
      #1 chk("oe_on", 0, tp_oe_n_o);
      chk("tp_low", {1'b1, pll_i, scan_i, car_i}, tp_o[3:0]);
      chk("tp_hi", {3'b001, dsync_i, 2'b00}, tp_o[9:4]);
      give_verdict();
   end
endmodule : tb
